// >>> rtl/sarcc_params.svh
`ifndef SARCC_PARAMS_SVH
`define SARCC_PARAMS_SVH

// resolution and code points of the straight-binary output
`define SARCC_BITS        16
`define SARCC_CODE_ZERO   16'h0000
`define SARCC_CODE_MID    16'h8000
`define SARCC_CODE_FULL   16'hFFFF

// clock period and least time of one bit decision, in ns
`define SARCC_CLK_NS      4
`define SARCC_TBIT_NS     16
`define SARCC_TBIT_CYC    ((`SARCC_TBIT_NS + `SARCC_CLK_NS - 1) / `SARCC_CLK_NS)

// reset values
`define SARCC_SPAN_RST    1'b0
`define SARCC_FLAG_N_RST  1'b1

`endif

// >>> rtl/sarcc_pkg.sv
`default_nettype none

package sarcc_pkg;

   typedef enum logic [1:0] {
      SARCC_ACQUIRE = 2'b00,
      SARCC_SAMPLE  = 2'b01,
      SARCC_RESOLVE = 2'b10,
      SARCC_FINISH  = 2'b11
   } sarcc_state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } sarcc_result_t;

   typedef struct packed {
      logic convert_start;
      logic comparator;
      logic above_range;
      logic below_range;
      logic clamp_active;
   } sarcc_pins_t;

endpackage

`default_nettype wire

// >>> rtl/sarcc_core.sv
// Behaviour
// - host raises convert start after acquisition; rising edge starts conversion, ends acquisition.
// - convert the input held at end of acquisition, not the live input.
// - sixteen binary-weighted successive-approximation steps, MSB first down to LSB.
// - at end of bit decisions form output code and clear busy state.
// - conversion paced by internal conversion clock, no serial clock needed.
// - straight binary codes: 0x0000 bottom, 0x8000 midscale, 0xFFFF top.
// - input above reference (0.9 reference when compressed) gives all-ones code.
// - input below zero (0.1 reference when compressed) gives all-zeros code.
// - span compression maps all codes onto 10% to 90% of reference.
// - overvoltage flag set while input clamp conducts.
// - overvoltage flag is active low; zero means overvoltage occurred.
// - flag is sticky, read-only, cleared only by read with condition gone.
// - span compression off after reset until host writes the bit.
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_params.svh"

module sarcc_core #(
   parameter int           BITS     = `SARCC_BITS,
   parameter logic [7:0]   TBIT_CYC = 8'(`SARCC_TBIT_CYC)
) (
   // clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    rst_n_i,
   // pins and analog decisions, asynchronous to clock_i
   input  wire sarcc_pkg::sarcc_pins_t  pins_i,
   // configuration write and flag read, same clock
   input  wire logic                    span_write_i,
   input  wire logic                    span_value_i,
   input  wire logic                    flag_read_i,
   // analog control
   output logic                         hold_o,
   output logic [BITS-1:0]              dac_code_o,
   output logic                         span_comp_o,
   // conversion status and result
   output logic                         busy_o,
   output sarcc_pkg::sarcc_result_t     result_o,
   output logic                         overvoltage_flag_n_o
);

   localparam int BIDX_W = $clog2(BITS);

   // two-stage synchronisers, one per pin
   sarcc_pkg::sarcc_pins_t pins_s1_reg;
   sarcc_pkg::sarcc_pins_t pins_s2_reg;
   logic                   start_prev_reg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
      end else begin
         pins_s1_reg <= pins_i;
         pins_s2_reg <= pins_s1_reg;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_prev_reg <= 1'b0;
      end else begin
         start_prev_reg <= pins_s2_reg.convert_start;
      end
   end

   logic start_edge;
   assign start_edge = pins_s2_reg.convert_start & ~start_prev_reg;

   // state
   sarcc_pkg::sarcc_state_t state_reg;
   sarcc_pkg::sarcc_state_t state_next;
   logic [7:0]              div_reg;
   logic                    tick;
   logic [BITS-1:0]         trial_reg;
   logic [BIDX_W-1:0]       bidx_reg;
   logic                    over_reg;
   logic                    under_reg;
   logic                    span_reg;
   logic                    span_conv_reg;
   sarcc_pkg::sarcc_result_t result_reg;
   logic                    flag_n_reg;

   // conversion clock: one tick per bit time, aligned to the start
   assign tick = (div_reg == TBIT_CYC - 8'h01);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_reg <= 8'h00;
      end else if (state_reg == sarcc_pkg::SARCC_ACQUIRE || tick) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         sarcc_pkg::SARCC_ACQUIRE: begin
            if (start_edge) begin
               state_next = sarcc_pkg::SARCC_SAMPLE;
            end
         end
         sarcc_pkg::SARCC_SAMPLE: begin
            if (tick) begin
               state_next = sarcc_pkg::SARCC_RESOLVE;
            end
         end
         sarcc_pkg::SARCC_RESOLVE: begin
            if (tick && bidx_reg == '0) begin
               state_next = sarcc_pkg::SARCC_FINISH;
            end
         end
         sarcc_pkg::SARCC_FINISH: begin
            state_next = sarcc_pkg::SARCC_ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= sarcc_pkg::SARCC_ACQUIRE;
      end else begin
         state_reg <= state_next;
      end
   end

   // successive approximation, MSB trial first
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trial_reg <= '0;
         bidx_reg  <= '0;
      end else if (state_reg == sarcc_pkg::SARCC_ACQUIRE && start_edge) begin
         trial_reg <= `SARCC_CODE_MID;
         bidx_reg  <= BIDX_W'(BITS - 1);
      end else if (state_reg == sarcc_pkg::SARCC_RESOLVE && tick) begin
         if (!pins_s2_reg.comparator) begin
            trial_reg[bidx_reg] <= 1'b0;
         end
         if (bidx_reg != '0) begin
            trial_reg[bidx_reg - BIDX_W'(1)] <= 1'b1;
            bidx_reg                         <= bidx_reg - BIDX_W'(1);
         end
      end
   end

   // range flags caught once the sample is held
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         over_reg  <= 1'b0;
         under_reg <= 1'b0;
      end else if (state_reg == sarcc_pkg::SARCC_SAMPLE && tick) begin
         over_reg  <= pins_s2_reg.above_range;
         under_reg <= pins_s2_reg.below_range;
      end
   end

   // span compression bit and its copy frozen for one conversion
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         span_reg <= `SARCC_SPAN_RST;
      end else if (span_write_i) begin
         span_reg <= span_value_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         span_conv_reg <= `SARCC_SPAN_RST;
      end else if (state_reg == sarcc_pkg::SARCC_ACQUIRE) begin
         span_conv_reg <= span_reg;
      end
   end

   // result formed at finish; code otherwise held, valid high for that one cycle only
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_reg <= '0;
      end else if (state_reg == sarcc_pkg::SARCC_FINISH) begin
         result_reg.valid <= 1'b1;
         if (over_reg) begin
            result_reg.code <= `SARCC_CODE_FULL;
         end else if (under_reg) begin
            result_reg.code <= `SARCC_CODE_ZERO;
         end else begin
            result_reg.code <= trial_reg;
         end
      end else begin
         result_reg.valid <= 1'b0;
      end
   end

   // sticky active-low clamp flag; a new clamp wins over a clearing read
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_n_reg <= `SARCC_FLAG_N_RST;
      end else if (pins_s2_reg.clamp_active) begin
         flag_n_reg <= 1'b0;
      end else if (flag_read_i) begin
         flag_n_reg <= 1'b1;
      end
   end

   assign hold_o               = (state_reg != sarcc_pkg::SARCC_ACQUIRE);
   assign busy_o               = (state_reg != sarcc_pkg::SARCC_ACQUIRE);
   assign dac_code_o           = trial_reg;
   assign span_comp_o          = span_conv_reg;
   assign result_o             = result_reg;
   assign overvoltage_flag_n_o = flag_n_reg;

   // checking helpers
   localparam int BUSY_MAX = 200;
   logic [4:0] steps_reg;
   logic [7:0] busy_cnt_reg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         steps_reg <= 5'h00;
      end else if (state_reg == sarcc_pkg::SARCC_SAMPLE) begin
         steps_reg <= 5'h00;
      end else if (state_reg == sarcc_pkg::SARCC_RESOLVE && tick) begin
         steps_reg <= steps_reg + 5'h01;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_cnt_reg <= 8'h00;
      end else if (!busy_o) begin
         busy_cnt_reg <= 8'h00;
      end else if (busy_cnt_reg != 8'hFF) begin
         busy_cnt_reg <= busy_cnt_reg + 8'h01;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   chk_start_busy: assert property (
      (state_reg == sarcc_pkg::SARCC_ACQUIRE && start_edge) |=> busy_o && hold_o)
      else $error("conversion did not start on convert edge");

   chk_no_restart: assert property (
      (busy_o && start_edge && state_reg != sarcc_pkg::SARCC_FINISH) |=> busy_o)
      else $error("edge during conversion disturbed it");

   chk_range_held: assert property (
      (state_reg == sarcc_pkg::SARCC_RESOLVE) |=> $stable(over_reg) && $stable(under_reg))
      else $error("range flags changed during resolve");

   chk_msb_first: assert property (
      (state_reg == sarcc_pkg::SARCC_SAMPLE) |-> dac_code_o == `SARCC_CODE_MID)
      else $error("first trial is not the msb");

   chk_bit_count: assert property (
      (state_reg == sarcc_pkg::SARCC_FINISH) |-> steps_reg == 5'd16)
      else $error("wrong number of bit decisions");

   chk_result_form: assert property (
      (state_reg == sarcc_pkg::SARCC_FINISH && !over_reg && !under_reg)
      |=> result_o.valid && result_o.code == $past(trial_reg) && !busy_o)
      else $error("result not formed from trial code");

   chk_busy_bound: assert property (
      $rose(busy_o) |-> ##[60:BUSY_MAX] !busy_o)
      else $error("conversion length out of bounds");

   chk_busy_len: assert property (
      $fell(busy_o) |-> busy_cnt_reg == 8'h45)
      else $error("conversion length not seventeen ticks plus one");

   chk_over_sat: assert property (
      (state_reg == sarcc_pkg::SARCC_FINISH && over_reg) |=> result_o.code == `SARCC_CODE_FULL)
      else $error("overrange did not give all ones");

   chk_under_sat: assert property (
      (state_reg == sarcc_pkg::SARCC_FINISH && under_reg && !over_reg)
      |=> result_o.code == `SARCC_CODE_ZERO)
      else $error("underrange did not give all zeros");

   chk_span_frozen: assert property (
      busy_o && $past(busy_o) |-> $stable(span_comp_o))
      else $error("span setting changed inside a conversion");

   chk_span_write: assert property (
      !span_write_i |=> $stable(span_reg))
      else $error("span bit changed without a write");

   chk_flag_set: assert property (
      pins_s2_reg.clamp_active |=> !overvoltage_flag_n_o)
      else $error("clamp did not pull flag low");

   chk_flag_sticky: assert property (
      (!overvoltage_flag_n_o && !flag_read_i) |=> !overvoltage_flag_n_o)
      else $error("flag cleared without a read");

   chk_flag_clear: assert property (
      (flag_read_i && !pins_s2_reg.clamp_active) |=> overvoltage_flag_n_o)
      else $error("read with no clamp did not clear flag");

   chk_result_hold: assert property (
      (state_reg != sarcc_pkg::SARCC_FINISH) |=> $stable(result_o.code))
      else $error("result changed outside finish");

endmodule

`default_nettype wire

// >>> test/sarcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module sarcc_analog_model (
   // clock and analog control from the core
   input  wire logic               clock_i,
   input  wire logic               hold_i,
   input  wire logic [15:0]        dac_code_i,
   input  wire logic               span_i,
   // input level in lsb steps, may lie outside the range
   input  wire logic signed [17:0] vin_i,
   // decisions back to the core
   output logic                    comparator_o,
   output logic                    above_o,
   output logic                    below_o
);
   logic signed [17:0] held_reg;
   int                 held_int;

   assign held_int = held_reg;

   // track while acquiring, freeze once the core holds
   always_ff @(posedge clock_i) begin
      if (!hold_i) begin
         held_reg <= vin_i;
      end
   end

   always_comb begin
      if (span_i) begin
         // levels times ten: offset of a tenth of range, 0.8 lsb per code
         comparator_o = 10 * held_int >= 65536 + 8 * int'(dac_code_i);
         above_o      = 10 * held_int > 589824;
         below_o      = 10 * held_int < 65536;
      end else begin
         comparator_o = held_reg >= $signed({2'b00, dac_code_i});
         above_o      = held_reg > 18'sh0FFFF;
         below_o      = held_reg < 18'sh00000;
      end
   end
endmodule

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic                     clock_i = 1'b0;
   logic                     rst_n_i = 1'b0;
   logic                     span_write_i = 1'b0;
   logic                     span_value_i = 1'b0;
   logic                     flag_read_i = 1'b0;
   logic                     span_mode = 1'b0;
   logic                     start = 1'b0;
   logic                     clamp = 1'b0;
   logic signed [17:0]       vin = '0;
   logic                     cmp, above, below;
   logic                     hold_o, span_comp_o, busy_o, clamp_flag_n;
   logic [15:0]              dac_code_o;
   sarcc_pkg::sarcc_pins_t   pins;
   sarcc_pkg::sarcc_result_t result_o;
   int                       error_cnt = 0;
   int                       n_compared = 0;
   int                       seed = 32'h0609DA53;

   assign pins = '{convert_start: start, comparator: cmp, above_range: above,
                   below_range: below, clamp_active: clamp};

   sarcc_core u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pins_i(pins),
      .span_write_i(span_write_i), .span_value_i(span_value_i),
      .flag_read_i(flag_read_i), .hold_o(hold_o), .dac_code_o(dac_code_o),
      .span_comp_o(span_comp_o), .busy_o(busy_o), .result_o(result_o),
      .overvoltage_flag_n_o(clamp_flag_n)
   );

   sarcc_analog_model u_model (
      .clock_i(clock_i), .hold_i(hold_o), .dac_code_i(dac_code_o), .span_i(span_comp_o),
      .vin_i(vin),
      .comparator_o(cmp), .above_o(above), .below_o(below)
   );

   initial begin
      forever #2 clock_i = ~clock_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // behavioural expectation: saturate at the end codes, else straight binary
   task automatic convert(input logic signed [17:0] v);
      int          n;
      logic [15:0] exp;
      logic [15:0] prev;
      int          vi;
      vin = v;
      prev = result_o.code;
      vi = v;
      if (!span_mode) begin
         exp = (v > 18'sh0FFFF) ? 16'hFFFF : (v < 0) ? 16'h0000 : v[15:0];
      end else if (10 * vi > 589824) begin
         exp = 16'hFFFF;
      end else if (10 * vi < 65536) begin
         exp = 16'h0000;
      end else begin
         exp = 16'((10 * vi - 65536) / 8);
      end
      cyc(2);
      start = 1'b1;
      n = 0;
      while (busy_o !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      check(busy_o, 1);
      check(hold_o, 1);
      n = 0;
      while (busy_o === 1'b1 && n < 200) begin
         if (n == 2) vin = v ^ 18'sh0F0F0;
         if (n == 5) start = 1'b0;
         if (n == 10) start = 1'b1;
         if (n == 20) start = 1'b0;
         check(result_o.code, prev);
         cyc(1);
         n++;
      end
      check(n, 69);
      check(result_o.valid, 1);
      check(result_o.code, exp);
      cyc(8);
      check(busy_o, 0);
      check(result_o.code, exp);
   endtask

   task automatic write_span(input logic val);
      span_write_i = 1'b1;
      span_value_i = val;
      span_mode = val;
      cyc(1);
      span_write_i = 1'b0;
      cyc(1);
      check(span_comp_o, val);
   endtask

   task automatic read_flag;
      flag_read_i = 1'b1;
      cyc(1);
      flag_read_i = 1'b0;
      cyc(1);
   endtask

   initial begin
      logic signed [17:0] pts [8];
      pts = '{18'sh08000, 18'sh07FFF, 18'sh08001, 18'sh00000,
              18'sh00001, 18'sh0FFFF, 18'sh11170, -18'sh00005};
      cyc(10);
      rst_n_i = 1'b1;
      cyc(1);
      check(span_comp_o, 0);
      check(clamp_flag_n, 1);
      foreach (pts[i]) convert(pts[i]);
      write_span(1'b1);
      for (int i = 0; i < 6; i++) convert(18'($random(seed) % 70000));
      convert(18'sh1FFFF);
      write_span(1'b0);
      clamp = 1'b1;
      cyc(4);
      check(clamp_flag_n, 0);
      read_flag();
      check(clamp_flag_n, 0);
      clamp = 1'b0;
      cyc(4);
      check(clamp_flag_n, 0);
      read_flag();
      check(clamp_flag_n, 1);
      give_verdict();
   end

   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
endmodule

`default_nettype wire
